// file: iad_decoder.sv
`timescale 1ns/100ps
module iad_decoder
   import iad_pkg::*;
(
   // clock and reset
   input  wire logic                 i_clk,
   input  wire logic                 i_rst_n,
   // pointer byte loads from the core
   input  wire logic                 i_ptr_we,
   input  wire logic                 i_ptr_sel,
   input  wire logic                 i_ptr_hi,
   input  wire logic [7:0]           i_ptr_data,
   // virtual port access from the core
   input  wire logic                 i_acc_req,
   input  wire logic                 i_acc_wr,
   input  wire logic                 i_acc_sel,
   input  wire logic [7:0]           i_acc_wdata,
   // data memory side
   output logic      [IAD_DM_AW-1:0] o_dm_addr,
   output logic                      o_dm_rd,
   output logic                      o_dm_wr,
   output logic      [7:0]           o_dm_wdata,
   input  wire logic [7:0]           i_dm_rdata,
   // program flash side, read only
   output logic      [IAD_PF_AW-1:0] o_pf_addr,
   output logic                      o_pf_rd,
   input  wire logic [IAD_PF_DW-1:0] i_pf_rdata,
   // answer to the core
   output logic      [7:0]           o_rdata,
   output logic                      o_done,
   output logic                      o_busy,
   output iad_tgt_s                  o_target,
   output logic      [IAD_PTR_W-1:0] o_ptr0,
   output logic      [IAD_PTR_W-1:0] o_ptr1
);
   import iad_pkg::*;

   // pointer storage, one pair per pointer
   logic [IAD_PTR_W-1:0] ptr      [IAD_NUM_PTR];
   logic [IAD_PTR_W-1:0] next_ptr [IAD_NUM_PTR];

   // access sequencing state
   iad_state_e           state;
   iad_state_e           next_state;
   logic [IAD_DM_AW-1:0] next_dm_addr;
   logic                 next_dm_rd;
   logic                 next_dm_wr;
   logic [7:0]           next_dm_wdata;
   logic [IAD_PF_AW-1:0] next_pf_addr;
   logic                 next_pf_rd;
   logic [7:0]           next_rdata;
   logic                 next_done;
   logic                 next_busy;
   iad_tgt_s             next_target;

   // decode of the selected pointer
   logic [IAD_PTR_W-1:0] cur_ptr;   // pointer named by the request
   iad_region_e          region;    // region it falls in
   logic                 is_port;   // points at the virtual port itself
   logic [IAD_DM_AW-1:0] lin_addr;  // linear view translated
   logic [IAD_DM_AW-1:0] dm_target; // data address for this access

   // the translator is shared by both pointers
   iad_lin_xlate u_lin
   (
      .i_ptr     (cur_ptr),
      .o_dm_addr (lin_addr)
   );

   // region decode; flash bit checked first since it overrides all
   always_comb
   begin
      cur_ptr = ptr[i_acc_sel];
      if (cur_ptr[IAD_PF_SEL_BIT])
         region = IAD_RG_PF;
      else if (cur_ptr <= IAD_ABS_LAST)
         region = IAD_RG_ABS;
      else if (cur_ptr >= IAD_LIN_FIRST && cur_ptr <= IAD_LIN_LAST)
         region = IAD_RG_LIN;
      else
         region = IAD_RG_NONE;
      // every bank mirrors the port at its first two offsets
      is_port   = (region == IAD_RG_ABS)
                  && (cur_ptr[IAD_BANK_OFS_W-1:0] <= IAD_PORT_LAST);
      dm_target = (region == IAD_RG_LIN) ? lin_addr
                                         : cur_ptr[IAD_DM_AW-1:0];
   end

   // pointer byte loads; the core may reload between accesses
   always_comb
   begin
      for (int i = 0; i < IAD_NUM_PTR; i++)
      begin
         next_ptr[i] = ptr[i];
         if (i_ptr_we && (i_ptr_sel == 1'(i)))
         begin
            if (i_ptr_hi)
               next_ptr[i][15:8] = i_ptr_data;
            else
               next_ptr[i][7:0] = i_ptr_data;
         end
      end
   end

   // pointer registers
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         for (int i = 0; i < IAD_NUM_PTR; i++)
            ptr[i] <= IAD_PTR_RST;
         o_ptr0 <= IAD_PTR_RST;
         o_ptr1 <= IAD_PTR_RST;
      end
      else
      begin
         for (int i = 0; i < IAD_NUM_PTR; i++)
            ptr[i] <= next_ptr[i];
         o_ptr0 <= next_ptr[0];
         o_ptr1 <= next_ptr[1];
      end
   end

   // access sequencer: strobes are single-cycle, addresses hold
   always_comb
   begin
      next_state    = state;
      next_dm_addr  = o_dm_addr;
      next_dm_rd    = 1'b0;
      next_dm_wr    = 1'b0;
      next_dm_wdata = o_dm_wdata;
      next_pf_addr  = o_pf_addr;
      next_pf_rd    = 1'b0;
      next_rdata    = o_rdata;
      next_done     = 1'b0;
      next_busy     = o_busy;
      next_target   = o_target;
      unique case (state)
         IAD_IDLE:
         begin
            // requests are only taken while idle
            if (i_acc_req)
            begin
               next_state = IAD_MEM;
               next_busy  = 1'b1;
               if (region == IAD_RG_PF)
               begin
                  next_pf_addr          = cur_ptr[IAD_PF_AW-1:0];
                  next_pf_rd            = !i_acc_wr;
                  next_target.is_pf     = 1'b1;
                  next_target.read_only = 1'b1;
                  next_target.addr      = cur_ptr[IAD_PF_AW-1:0];
               end
               else
               begin
                  // mapped data memory only; port and holes are dead
                  next_dm_addr = dm_target;
                  next_dm_rd   = !i_acc_wr && !is_port
                                 && (region != IAD_RG_NONE);
                  next_dm_wr   = i_acc_wr && !is_port
                                 && (region != IAD_RG_NONE);
                  next_dm_wdata         = i_acc_wdata;
                  next_target.is_pf     = 1'b0;
                  next_target.read_only = 1'b0;
                  next_target.addr      = IAD_PF_AW'(dm_target);
               end
            end
         end
         IAD_MEM:
         begin
            if (o_target.is_pf)
            begin
               // only the low byte of the word reaches the data path
               next_rdata = o_pf_rd ? i_pf_rdata[7:0] : IAD_READ_ZERO;
               next_state = IAD_XTRA;
            end
            else
            begin
               // no read strobe means a write, port or hole: answer zero
               next_rdata = o_dm_rd ? i_dm_rdata : IAD_READ_ZERO;
               next_state = IAD_IDLE;
               next_done  = 1'b1;
               next_busy  = 1'b0;
            end
         end
         IAD_XTRA:
         begin
            // the extra cycle only delays done; the flash byte was already taken in IAD_MEM
            next_state = IAD_IDLE;
            next_done  = 1'b1;
            next_busy  = 1'b0;
         end
      endcase
   end

   // access registers feeding every output but o_ptr0 and o_ptr1 straight
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state      <= IAD_IDLE;
         o_dm_addr  <= '0;
         o_dm_rd    <= 1'b0;
         o_dm_wr    <= 1'b0;
         o_dm_wdata <= 8'h00;
         o_pf_addr  <= '0;
         o_pf_rd    <= 1'b0;
         o_rdata    <= IAD_READ_ZERO;
         o_done     <= 1'b0;
         o_busy     <= 1'b0;
         o_target   <= '0;
      end
      else
      begin
         state      <= next_state;
         o_dm_addr  <= next_dm_addr;
         o_dm_rd    <= next_dm_rd;
         o_dm_wr    <= next_dm_wr;
         o_dm_wdata <= next_dm_wdata;
         o_pf_addr  <= next_pf_addr;
         o_pf_rd    <= next_pf_rd;
         o_rdata    <= next_rdata;
         o_done     <= next_done;
         o_busy     <= next_busy;
         o_target   <= next_target;
      end
   end

   // checks on the design's own behaviour
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   // a taken request, split by region
   sequence s_take_pf;
      state == IAD_IDLE && i_acc_req && region == IAD_RG_PF;
   endsequence
   sequence s_take_dm;
      state == IAD_IDLE && i_acc_req && region != IAD_RG_PF;
   endsequence
   // flash answer: busy, extra cycle, then done
   sequence s_pf_answer;
      (o_busy && !o_done) [*2] ##1 (o_done && !o_busy);
   endsequence

   property p_port_silent;
      state == IAD_IDLE && i_acc_req && is_port |->
         ##1 (!o_dm_wr && !o_dm_rd) ##1 (o_done && o_rdata == IAD_READ_ZERO);
   endproperty
   a_port_silent: assert property (p_port_silent)
      else $error("virtual port access was not suppressed");

   property p_abs_map;
      state == IAD_IDLE && i_acc_req && region == IAD_RG_ABS && !is_port && !i_acc_wr |->
         ##1 (o_dm_rd && o_dm_addr == $past(cur_ptr[IAD_DM_AW-1:0]));
   endproperty
   a_abs_map: assert property (p_abs_map)
      else $error("absolute pointer not passed to data memory");

   property p_lin_map;
      state == IAD_IDLE && i_acc_req && region == IAD_RG_LIN |->
         ##1 (o_dm_addr[6:0] >= IAD_GPR_BASE && o_dm_addr[6:0] < 7'h70
              && 32'(o_dm_addr[11:7]) * 80 + 32'(o_dm_addr[6:0]) - 32
                 == 32'($past(cur_ptr)) - 32'h2000);
   endproperty
   a_lin_map: assert property (p_lin_map)
      else $error("linear pointer translated wrongly");

   property p_pf_addr;
      s_take_pf and (!i_acc_wr) |->
         ##1 (o_pf_rd && !o_dm_rd && o_pf_addr == $past(cur_ptr[IAD_PF_AW-1:0]));
   endproperty
   a_pf_addr: assert property (p_pf_addr)
      else $error("flash word address not issued");

   property p_pf_low_byte;
      state == IAD_MEM && o_pf_rd |->
         ##2 (o_done && o_rdata == $past(i_pf_rdata[7:0], 2));
   endproperty
   a_pf_low_byte: assert property (p_pf_low_byte)
      else $error("flash low byte not delivered");

   property p_pf_no_write;
      s_take_pf and (i_acc_wr) |-> ##1 (!o_dm_wr && !o_pf_rd) [*3];
   endproperty
   a_pf_no_write: assert property (p_pf_no_write)
      else $error("write to flash region reached a memory");

   property p_pf_extra;
      s_take_pf |-> ##1 s_pf_answer;
   endproperty
   a_pf_extra: assert property (p_pf_extra)
      else $error("flash access did not take one extra cycle");

   property p_dm_timing;
      s_take_dm |-> ##1 (o_busy && !o_done) ##1 (o_done && !o_busy);
   endproperty
   a_dm_timing: assert property (p_dm_timing)
      else $error("data access answer not on time");

   property p_hole_zero;
      state == IAD_IDLE && i_acc_req && region == IAD_RG_NONE |->
         ##1 (!o_dm_rd && !o_dm_wr) ##1 (o_rdata == IAD_READ_ZERO);
   endproperty
   a_hole_zero: assert property (p_hole_zero)
      else $error("unmapped pointer touched memory or read nonzero");

   property p_write_redirect;
      s_take_dm and (i_acc_wr && !is_port && region != IAD_RG_NONE) |->
         ##1 (o_dm_wr && o_dm_wdata == $past(i_acc_wdata)
              && o_dm_addr == $past(dm_target));
   endproperty
   a_write_redirect: assert property (p_write_redirect)
      else $error("port write not redirected to pointed location");
endmodule : iad_decoder

// file: iad_lin_xlate.sv
`timescale 1ns/100ps
module iad_lin_xlate
   import iad_pkg::*;
(
   // linear pointer in
   input  wire logic [IAD_PTR_W-1:0] i_ptr,
   // absolute data memory address out
   output logic      [IAD_DM_AW-1:0] o_dm_addr
);
   import iad_pkg::*;

   logic [IAD_DM_AW-1:0]      lin_ofs;  // distance from start of region
   logic [IAD_DM_AW-1:0]      quot;     // bank number
   logic [IAD_DM_AW-1:0]      remd;     // byte within banked ram
   logic [IAD_BANK_OFS_W-1:0] bank_ofs; // location within the bank

   // constant divide; the region is small so the divider stays shallow
   always_comb
   begin
      lin_ofs   = IAD_DM_AW'(i_ptr - IAD_LIN_FIRST);
      quot      = lin_ofs / IAD_GPR_BYTES;
      remd      = lin_ofs % IAD_GPR_BYTES;
      bank_ofs  = IAD_BANK_OFS_W'(remd) + IAD_GPR_BASE;
      o_dm_addr = {quot[IAD_BANK_W-1:0], bank_ofs};
   end
endmodule : iad_lin_xlate

// file: iad_mem_model.sv
`timescale 1ns/100ps
// data memory and program flash standing behind the decoder
module iad_mem_model
   import iad_pkg::*;
(
   // clock
   input  wire logic                 i_clk,
   // data memory port
   input  wire logic [IAD_DM_AW-1:0] i_dm_addr,
   input  wire logic                 i_dm_rd,
   input  wire logic                 i_dm_wr,
   input  wire logic [7:0]           i_dm_wdata,
   output logic      [7:0]           o_dm_rdata,
   // flash port, read only
   input  wire logic [IAD_PF_AW-1:0] i_pf_addr,
   input  wire logic                 i_pf_rd,
   output logic      [IAD_PF_DW-1:0] o_pf_rdata
);
   logic [7:0]           mem [0:4095]; // byte store, seeded with a pattern
   logic [7:0]           last_dm;      // last byte put on the data bus
   logic [IAD_PF_DW-1:0] last_pf;      // last flash word put on the bus

   // seed pattern, the bench mirrors the same one
   initial
   begin
      for (int a = 0; a < 4096; a++)
         mem[a] = a[7:0] ^ 8'h5A;
      last_dm = 8'h00;
      last_pf = 14'h0000;
   end

   // combinational read; outside a strobe the inverse of the last value
   // is shown so that a stale byte can never pass for a fresh one
   always_comb
   begin
      o_dm_rdata = i_dm_rd ? mem[i_dm_addr] : ~last_dm;
      o_pf_rdata = i_pf_rd ? (i_pf_addr[13:0] ^ {i_pf_addr[14:9], 8'hC3}) : ~last_pf;
   end

   // writes land on the edge that sees the strobe
   always @(posedge i_clk)
   begin
      if (i_dm_rd)
         last_dm <= mem[i_dm_addr];
      if (i_dm_wr)
         mem[i_dm_addr] <= i_dm_wdata;
      if (i_pf_rd)
         last_pf <= o_pf_rdata;
   end
endmodule : iad_mem_model

// file: iad_pkg.sv
package iad_pkg;
   // pointer and memory widths
   localparam int          IAD_PTR_W      = 16;
   localparam int          IAD_DM_AW      = 12;
   localparam int          IAD_PF_AW      = 15;
   localparam int          IAD_PF_DW      = 14;
   localparam int          IAD_NUM_PTR    = 2;
   // region limits of the pointer space
   localparam logic [15:0] IAD_ABS_LAST   = 16'h0FFF;
   localparam logic [15:0] IAD_LIN_FIRST  = 16'h2000;
   localparam logic [15:0] IAD_LIN_LAST   = 16'h29AF;
   localparam int          IAD_PF_SEL_BIT = 15;
   // bank layout: 128 locations, banked ram from 0x20, 80 bytes long
   localparam int          IAD_BANK_OFS_W = 7;
   localparam int          IAD_BANK_W     = 5;
   localparam logic [11:0] IAD_GPR_BYTES  = 12'h050;
   localparam logic [6:0]  IAD_GPR_BASE   = 7'h20;
   // virtual port sits at bank offsets 0 and 1
   localparam logic [6:0]  IAD_PORT_LAST  = 7'h01;
   // values after reset and the fixed read answer
   localparam logic [15:0] IAD_PTR_RST    = 16'h0000;
   localparam logic [7:0]  IAD_READ_ZERO  = 8'h00;
   // extra instruction cycles for a flash access
   localparam int          IAD_PF_EXTRA   = 1;

   // sequencing of one access
   typedef enum logic [1:0] {IAD_IDLE, IAD_MEM, IAD_XTRA} iad_state_e;

   // which region a pointer falls in
   typedef enum logic [1:0] {IAD_RG_ABS, IAD_RG_LIN, IAD_RG_PF, IAD_RG_NONE} iad_region_e;

   // resolved physical target handed to the core
   typedef struct packed {
      logic                 is_pf;
      logic                 read_only;
      logic [IAD_PF_AW-1:0] addr;
   } iad_tgt_s;
endpackage : iad_pkg

// file: iad_tb.sv
`timescale 1ns/100ps
module tb;
   import iad_pkg::*;
   // stimulus, all set at time zero
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_ptr_we = 1'b0;
   logic i_ptr_sel = 1'b0;
   logic i_ptr_hi = 1'b0;
   logic [7:0] i_ptr_data = 8'h00;
   logic i_acc_req = 1'b0;
   logic i_acc_wr = 1'b0;
   logic i_acc_sel = 1'b0;
   logic [7:0] i_acc_wdata = 8'h00;
   // design answers
   wire logic [11:0] o_dm_addr;
   wire logic [7:0] o_dm_wdata, i_dm_rdata, o_rdata;
   wire logic o_dm_rd, o_dm_wr, o_pf_rd, o_done, o_busy;
   wire logic [14:0] o_pf_addr;
   wire logic [13:0] i_pf_rdata;
   wire logic [15:0] o_ptr0, o_ptr1;
   iad_tgt_s o_target;
   // reference state
   logic [7:0] ref_mem [0:4095];
   logic [15:0] ptr [0:1];
   int error_cnt = 0;
   int comparisons = 0;

   always #25 i_clk = ~i_clk;

   iad_decoder dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ptr_we(i_ptr_we),
      .i_ptr_sel(i_ptr_sel), .i_ptr_hi(i_ptr_hi), .i_ptr_data(i_ptr_data),
      .i_acc_req(i_acc_req), .i_acc_wr(i_acc_wr), .i_acc_sel(i_acc_sel),
      .i_acc_wdata(i_acc_wdata), .o_dm_addr(o_dm_addr), .o_dm_rd(o_dm_rd),
      .o_dm_wr(o_dm_wr), .o_dm_wdata(o_dm_wdata), .i_dm_rdata(i_dm_rdata),
      .o_pf_addr(o_pf_addr), .o_pf_rd(o_pf_rd), .i_pf_rdata(i_pf_rdata),
      .o_rdata(o_rdata), .o_done(o_done), .o_busy(o_busy), .o_target(o_target),
      .o_ptr0(o_ptr0), .o_ptr1(o_ptr1));

   iad_mem_model u_mem (.i_clk(i_clk), .i_dm_addr(o_dm_addr), .i_dm_rd(o_dm_rd),
      .i_dm_wr(o_dm_wr), .i_dm_wdata(o_dm_wdata), .o_dm_rdata(i_dm_rdata),
      .i_pf_addr(o_pf_addr), .i_pf_rd(o_pf_rd), .o_pf_rdata(i_pf_rdata));

   // counts the mismatch and prints both values
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("checks=%0d mismatches=%0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   // reference map: data address, -1 for no target, -2 for flash
   function automatic int map(input logic [15:0] p);
      int o;
      o = int'(p) - 32'h2000;
      if (p[15])
         return -2;
      if (p <= 16'h0FFF)
         return (p[6:0] <= 7'h01) ? -1 : int'(p);
      if (p >= 16'h2000 && p <= 16'h29AF)
         return (o / 80) * 128 + o % 80 + 32;
      return -1;
   endfunction : map

   // loads high then low byte back to back, called at a falling edge
   task automatic setp(input logic sel, input logic [15:0] v);
      i_ptr_we = 1'b1;
      i_ptr_sel = sel;
      i_ptr_hi = 1'b1;
      i_ptr_data = v[15:8];
      @(negedge i_clk);
      check(sel ? o_ptr1[15:8] : o_ptr0[15:8], v[15:8]);
      i_ptr_hi = 1'b0;
      i_ptr_data = v[7:0];
      @(negedge i_clk);
      i_ptr_we = 1'b0;
      ptr[sel] = v;
      check({o_ptr1, o_ptr0}, {ptr[1], ptr[0]});
   endtask : setp

   // one access; hold keeps the request up into the busy cycle
   task automatic acc(input logic sel, input logic wr, input logic hold);
      logic [15:0] p;
      logic [13:0] w;
      logic [7:0] wd;
      logic srd, swr, spf;
      int a, n;
      p = ptr[sel];
      a = map(p);
      w = p[13:0] ^ {p[14:9], 8'hC3};
      wd = 8'($urandom);
      {srd, swr, spf} = 3'h0;
      i_acc_req = 1'b1;
      i_acc_wr = wr;
      i_acc_sel = sel;
      i_acc_wdata = wd;
      @(negedge i_clk);
      i_acc_req = hold;
      n = 1;
      check(o_busy, 1'b1);
      check(o_target.is_pf, p[15]);
      // resolved target: flash word and read-only flag, or the data address
      if (a != -1)
         check(o_target, (a == -2) ? {2'b11, p[14:0]} : {2'b00, 15'(a)});
      while (o_done !== 1'b1 && n < 10)
      begin
         if (o_dm_rd === 1'b1 || o_dm_wr === 1'b1)
            check(o_dm_addr, a[11:0]);
         if (o_dm_wr === 1'b1)
            check(o_dm_wdata, wd);
         if (o_pf_rd === 1'b1)
            check({o_target.read_only, o_pf_addr}, {1'b1, p[14:0]});
         srd |= (o_dm_rd === 1'b1);
         swr |= (o_dm_wr === 1'b1);
         spf |= (o_pf_rd === 1'b1);
         @(negedge i_clk);
         i_acc_req = 1'b0;
         n++;
      end
      if (n >= 10)
      begin
         check(32'(n), 32'h0);
         complete_run();
      end
      check(32'(n), (a == -2) ? 32'h3 : 32'h2);
      check({srd, swr}, {a >= 0 && !wr, a >= 0 && wr});
      check(spf, a == -2 && !wr);
      check(o_busy, 1'b0);
      if (!wr)
         check(o_rdata, (a >= 0) ? ref_mem[a] : (a == -2) ? w[7:0] : 8'h00);
      if (wr && a >= 0)
         ref_mem[a] = wd;
      // the request held into the busy cycle must not start a second access
      for (int i = 0; i < 3 && hold; i++)
      begin
         @(negedge i_clk);
         check(o_done, 1'b0);
      end
   endtask : acc

   logic [15:0] dir [0:12] = '{16'h0020, 16'h0000, 16'h0081, 16'h0FFF, 16'h1000,
      16'h2000, 16'h204F, 16'h2050, 16'h29AF, 16'h29B0, 16'h7FFF, 16'h8000, 16'hFFFF};

   // main sequence
   initial
   begin
      logic [15:0] p;
      int r;
      for (int a = 0; a < 4096; a++)
         ref_mem[a] = a[7:0] ^ 8'h5A;
      ptr[0] = 16'h0000;
      ptr[1] = 16'h0000;
      void'($urandom(32'h2ee44bd6));
      repeat (5) @(negedge i_clk);
      i_rst_n = 1'b1;
      @(negedge i_clk);
      check({o_ptr1, o_ptr0}, 32'h0);
      check({o_busy, o_done}, 32'h0);
      $display("reset test done");
      // region edges, each written then read back
      foreach (dir[i])
      begin
         setp(dir[i][0], dir[i]);
         acc(dir[i][0], 1'b1, 1'b0);
         acc(dir[i][0], 1'b0, 1'b0);
      end
      $display("region edge test done");
      // linear write seen through the absolute view of bank 1
      setp(1'b1, 16'h2050);
      acc(1'b1, 1'b1, 1'b0);
      setp(1'b0, 16'h00A0);
      acc(1'b0, 1'b0, 1'b1);
      setp(1'b0, 16'h8123);
      acc(1'b0, 1'b0, 1'b1);
      $display("alias and refusal test done");
      // random traffic, two accesses back to back each time
      for (int k = 0; k < 300; k++)
      begin
         r = $urandom % 3;
         p = (r == 0) ? 16'($urandom % 4096) : (r == 1) ?
             16'h2000 + 16'($urandom % 2480) : 16'($urandom);
         setp(k[0], p);
         acc(k[0], 1'($urandom), 1'b0);
         acc(k[0], 1'($urandom), 1'b0);
      end
      $display("random test done");
      complete_run();
   end
endmodule : tb
